// >>> src/lbs_top.sv
// Operation
// - in entry mode, echo each entry; nominal entry shows stored nominal on primary display
// - after bin entry show absolute upper limit and lower limit's four leading digits
// - entering or recalling bin 0 shows secondary limit on secondary display
// - recall blanks the display when values do not fit the current multiplier
// - only the latest nominal is kept; older ones are gone
// - bin limits stay until that bin is re-entered; lost at reset
// - pass for bins 1 upward; fail with bin 0 secondary, bin 9 primary
// - zero percentage closes a bin until nonzero limits reopen it
// - secondary limit at all-pass extreme makes secondary check always pass
// - zero nominal inhibits comparisons and lamps; nonzero nominal restores them unchanged
// - bin 0 limit is upper for R/Q and C/D, lower for L/Q
// - at reset bins 1 to 8 are closed
// - nominal up to seven figures, percentages up to 99999.9
// - part matching several open bins goes to the lowest-numbered one
// - at reset the nominal is zero, so sorting starts inhibited
// - a single percentage is stored as a symmetrical plus/minus pair
// - changing the nominal leaves stored bin limits untouched
// - nominal is the reference for delta results in measure mode
// - each limit is nominal plus entered percentage of nominal, stored absolute
// - stored limits and results do not depend on test frequency
// - nominal capped at 999999.9; no nominal entry in display-only multiplier
// - nominal and bin entry and recall only in entry mode
// - a part in no open bin goes to bin 9
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
module lbs_top (
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             GO_LAMP,
  output logic             NOGO_LAMP,
  output logic [3:0]       BIN_CODE,
  output logic             SORT_DONE
);

  localparam int LW = lbs_pkg::LW;

  lbs_pkg::lbs_bus_t      bus_q;
  lbs_pkg::lbs_aph_t      aph_q;
  logic                   entry_q;
  logic [1:0]             mult_q;
  lbs_pkg::lbs_sel_t      sel_q;
  logic signed [31:0]     val_a_q;
  logic signed [31:0]     val_b_q;
  logic signed [31:0]     meas_pri_q;
  logic [31:0]            meas_sec_q;
  logic [23:0]            nom_q;
  logic [1:0]             nom_mult_q;
  lbs_pkg::lbs_bin_t      bins_q [1:lbs_pkg::NBINS];
  logic [31:0]            lim0_q;
  logic [31:0]            disp_pri_q;
  logic [31:0]            disp_sec_q;
  logic                   blank_q;
  logic                   refused_q;
  lbs_pkg::lbs_res_t      res_q;
  logic signed [31:0]     delta_q;

  logic                   wr_fire;
  logic                   cmd_go;
  lbs_pkg::lbs_op_t       cmd_op;
  logic [3:0]             cmd_bin;
  logic                   cmd_two;
  logic                   bin_rng;
  logic                   ent_go;
  logic                   sort_go;
  logic                   refuse;
  logic signed [20:0]     pct_a;
  logic signed [20:0]     pct_b;
  logic                   close_req;
  logic signed [LW-1:0]   new_hi;
  logic signed [LW-1:0]   new_lo;
  logic [23:0]            nom_in;
  logic                   nom_ok;
  logic [lbs_pkg::NBINS:1] open_mask;
  logic [lbs_pkg::NBINS:0] match_vec;
  logic [3:0]             hit_bin;
  logic                   hit;
  logic                   sec_fail;
  lbs_pkg::lbs_res_t      res_d;
  logic [3:0]             rb;
  logic [32:0]            cv_nom;
  logic [32:0]            cv_hi;
  logic [32:0]            cv_lo;
  logic                   disp_upd;
  logic [31:0]            disp_pri_d;
  logic [31:0]            disp_sec_d;
  logic                   blank_d;
  logic [31:0]            rd_word;

  function automatic logic signed [20:0] clamp_pct(input logic signed [31:0] x);
    if (x > lbs_pkg::PCT_CAP) begin
      return 21'(lbs_pkg::PCT_CAP);
    end else if (x < -lbs_pkg::PCT_CAP) begin
      return 21'(-lbs_pkg::PCT_CAP);
    end
    return 21'(x);
  endfunction : clamp_pct

  function automatic logic signed [LW-1:0] lim_of(input logic [23:0] nom, input logic signed [20:0] pct);
    logic signed [47:0] base;
    logic signed [47:0] prod;
    base = 48'($signed({1'b0, nom}));
    prod = base * 48'(pct);
    return LW'(base + prod / lbs_pkg::PCT_SCALE);
  endfunction : lim_of

  // rescale between multipliers; top bit flags a value too large to show
  function automatic logic [32:0] disp_conv(input logic signed [LW-1:0] v, input logic [1:0] from,
                                            input logic [1:0] to);
    logic signed [63:0] r;
    logic               blank;
    r = 64'(v);
    for (int i = 0; i < lbs_pkg::MULT_STEPS_MAX; i++) begin
      if (to < from && i < int'(from - to)) begin
        r = r * lbs_pkg::MULT_STEP;
      end else if (from < to && i < int'(to - from)) begin
        r = r / lbs_pkg::MULT_STEP;
      end
    end
    blank = (r > lbs_pkg::DISP_MAX) || (r < -lbs_pkg::DISP_MAX);
    return {blank, r[31:0]};
  endfunction : disp_conv

  function automatic logic [31:0] msd4(input logic signed [LW-1:0] v);
    logic signed [LW-1:0] m;
    m = (v < 0) ? -v : v;
    for (int i = 0; i < lbs_pkg::MSD_STEPS; i++) begin
      if (m > lbs_pkg::MSD4_MAX) begin
        m = m / lbs_pkg::DEC_BASE;
      end
    end
    return m[31:0];
  endfunction : msd4

  // ---------------- bus slave ----------------
  assign wr_fire = aph_q.sel && aph_q.write;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      aph_q     <= '0;
      bus_q     <= lbs_pkg::BUS_IDLE;
      HREADYOUT <= 1'b1;
      HRDATA    <= 32'h0000_0000;
      HRESP     <= 1'b0;
    end else begin
      HRESP <= 1'b0;
      case (bus_q)
        lbs_pkg::BUS_IDLE: begin
          if (HREADY) begin
            aph_q.sel   <= HSEL && HTRANS[1];
            aph_q.write <= HWRITE;
            aph_q.addr  <= HADDR[lbs_pkg::HADDR_W-1:0];
            if (HSEL && HTRANS[1] && !HWRITE) begin
              bus_q     <= lbs_pkg::BUS_READ;
              HREADYOUT <= 1'b0;
            end
          end
        end
        lbs_pkg::BUS_READ: begin
          HRDATA    <= rd_word;
          HREADYOUT <= 1'b1;
          aph_q.sel <= 1'b0;
          bus_q     <= lbs_pkg::BUS_IDLE;
        end
        default: begin
          bus_q     <= lbs_pkg::BUS_IDLE;
          HREADYOUT <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    case (aph_q.addr)
      lbs_pkg::OFF_CTRL:     rd_word = 32'({sel_q, mult_q, entry_q});
      lbs_pkg::OFF_VAL_A:    rd_word = val_a_q;
      lbs_pkg::OFF_VAL_B:    rd_word = val_b_q;
      lbs_pkg::OFF_DISP_PRI: rd_word = disp_pri_q;
      lbs_pkg::OFF_DISP_SEC: rd_word = disp_sec_q;
      lbs_pkg::OFF_STATUS:   rd_word = 32'({nom_q == '0, open_mask, refused_q, blank_q});
      lbs_pkg::OFF_MEAS_PRI: rd_word = meas_pri_q;
      lbs_pkg::OFF_MEAS_SEC: rd_word = meas_sec_q;
      lbs_pkg::OFF_RESULT:   rd_word = 32'(res_q);
      lbs_pkg::OFF_DELTA:    rd_word = delta_q;
      lbs_pkg::OFF_NOMINAL:  rd_word = 32'(nom_q);
      default:               rd_word = 32'h0000_0000;
    endcase
  end

  // ---------------- command decode ----------------
  assign cmd_go    = wr_fire && aph_q.addr == lbs_pkg::OFF_CMD;
  assign cmd_op    = lbs_pkg::lbs_op_t'(HWDATA[lbs_pkg::CMD_OP_LSB +: lbs_pkg::OP_W]);
  assign cmd_bin   = HWDATA[lbs_pkg::CMD_BIN_LSB +: lbs_pkg::BIN_W];
  assign cmd_two   = HWDATA[lbs_pkg::CMD_TWO_BIT];
  assign bin_rng   = cmd_bin >= lbs_pkg::BIN_FIRST && cmd_bin <= lbs_pkg::BIN_LAST;
  assign ent_go    = cmd_go && entry_q;
  assign sort_go   = cmd_go && cmd_op == lbs_pkg::OP_SORT && !entry_q;
  assign nom_ok    = mult_q <= lbs_pkg::MULT_ENTRY_MAX;
  assign pct_a     = clamp_pct(val_a_q);
  assign pct_b     = cmd_two ? clamp_pct(val_b_q) : -pct_a;
  assign close_req = pct_a == '0 && pct_b == '0;
  assign new_hi    = lim_of(nom_q, pct_a);
  assign new_lo    = lim_of(nom_q, pct_b);
  assign nom_in    = (val_a_q < 0) ? '0 :
                     (val_a_q > $signed({8'h00, lbs_pkg::NOM_CAP})) ? lbs_pkg::NOM_CAP : val_a_q[23:0];
  assign rb        = bin_rng ? cmd_bin : lbs_pkg::BIN_FIRST;

  always_comb begin
    refuse = 1'b0;
    if (cmd_go) begin
      case (cmd_op)
        lbs_pkg::OP_NOM:     refuse = !entry_q || !nom_ok;
        lbs_pkg::OP_BIN:     refuse = !entry_q || cmd_bin > lbs_pkg::BIN_LAST;
        lbs_pkg::OP_RCL_NOM: refuse = !entry_q;
        lbs_pkg::OP_RCL_BIN: refuse = !entry_q || cmd_bin > lbs_pkg::BIN_LAST;
        lbs_pkg::OP_SORT:    refuse = entry_q;
        default:             refuse = 1'b1;
      endcase
    end
  end

  // ---------------- software registers ----------------
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      entry_q    <= 1'b0;
      mult_q     <= 2'h0;
      sel_q      <= lbs_pkg::SEL_R_Q;
      val_a_q    <= '0;
      val_b_q    <= '0;
      meas_pri_q <= '0;
      meas_sec_q <= '0;
      refused_q  <= 1'b0;
    end else begin
      if (wr_fire) begin
        case (aph_q.addr)
          lbs_pkg::OFF_CTRL: begin
            entry_q <= HWDATA[lbs_pkg::CTRL_ENTRY_BIT];
            mult_q  <= HWDATA[lbs_pkg::CTRL_MULT_LSB +: 2];
            sel_q   <= lbs_pkg::lbs_sel_t'(HWDATA[lbs_pkg::CTRL_SEL_LSB +: 2]);
          end
          lbs_pkg::OFF_VAL_A:    val_a_q    <= HWDATA;
          lbs_pkg::OFF_VAL_B:    val_b_q    <= HWDATA;
          lbs_pkg::OFF_MEAS_PRI: meas_pri_q <= HWDATA;
          lbs_pkg::OFF_MEAS_SEC: meas_sec_q <= HWDATA;
          default: ;
        endcase
      end
      if (cmd_go) begin
        refused_q <= refuse;
      end
    end
  end

  // single nominal register: a new entry overwrites the old one
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      nom_q      <= '0;
      nom_mult_q <= 2'h0;
    end else if (ent_go && cmd_op == lbs_pkg::OP_NOM && nom_ok) begin
      nom_q      <= nom_in;
      nom_mult_q <= mult_q;
    end
  end

  // limits change only on an entry for that bin, never on a nominal change
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      for (int i = 1; i <= lbs_pkg::NBINS; i++) begin
        bins_q[i] <= '0;
      end
      lim0_q <= lbs_pkg::SEC_ALLPASS_HI;
    end else if (ent_go && cmd_op == lbs_pkg::OP_BIN) begin
      if (cmd_bin == lbs_pkg::BIN_SEC) begin
        lim0_q <= val_a_q;
      end else if (bin_rng) begin
        bins_q[cmd_bin].open <= !close_req;
        bins_q[cmd_bin].mult <= mult_q;
        bins_q[cmd_bin].hi   <= close_req ? '0 : new_hi;
        bins_q[cmd_bin].lo   <= close_req ? '0 : new_lo;
      end
    end
  end

  // ---------------- display ----------------
  assign cv_nom = disp_conv(LW'($signed({1'b0, nom_q})), nom_mult_q, mult_q);
  assign cv_hi  = disp_conv(bins_q[rb].hi, bins_q[rb].mult, mult_q);
  assign cv_lo  = disp_conv(bins_q[rb].lo, bins_q[rb].mult, mult_q);

  always_comb begin
    disp_upd   = 1'b0;
    disp_pri_d = disp_pri_q;
    disp_sec_d = disp_sec_q;
    blank_d    = 1'b0;
    if (ent_go && !refuse) begin
      case (cmd_op)
        lbs_pkg::OP_NOM: begin
          disp_upd   = 1'b1;
          disp_pri_d = 32'(nom_in);
        end
        lbs_pkg::OP_BIN: begin
          disp_upd = 1'b1;
          if (cmd_bin == lbs_pkg::BIN_SEC) begin
            disp_sec_d = val_a_q;
          end else begin
            disp_pri_d = close_req ? '0 : new_hi[31:0];
            disp_sec_d = close_req ? '0 : msd4(new_lo);
          end
        end
        lbs_pkg::OP_RCL_NOM: begin
          disp_upd   = 1'b1;
          disp_pri_d = cv_nom[31:0];
          blank_d    = cv_nom[32];
        end
        lbs_pkg::OP_RCL_BIN: begin
          disp_upd = 1'b1;
          if (cmd_bin == lbs_pkg::BIN_SEC) begin
            disp_sec_d = lim0_q;
          end else begin
            disp_pri_d = cv_hi[31:0];
            disp_sec_d = msd4(LW'($signed(cv_lo[31:0])));
            blank_d    = cv_hi[32] || cv_lo[32];
          end
        end
        default: disp_upd = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      disp_pri_q <= '0;
      disp_sec_q <= '0;
      blank_q    <= 1'b0;
    end else if (disp_upd) begin
      disp_pri_q <= disp_pri_d;
      disp_sec_q <= disp_sec_d;
      blank_q    <= blank_d;
    end
  end

  // ---------------- sorting ----------------
  always_comb begin
    match_vec = '0;
    open_mask = '0;
    for (int i = 1; i <= lbs_pkg::NBINS; i++) begin
      open_mask[i] = bins_q[i].open;
      match_vec[i] = bins_q[i].open && LW'(meas_pri_q) >= bins_q[i].lo
                     && LW'(meas_pri_q) <= bins_q[i].hi;
    end
  end

  always_comb begin
    hit     = 1'b0;
    hit_bin = lbs_pkg::BIN_FAIL;
    for (int i = lbs_pkg::NBINS; i >= 1; i--) begin
      if (match_vec[i]) begin
        hit     = 1'b1;
        hit_bin = 4'(i);
      end
    end
  end

  // limits are absolute and compared as stored, so frequency has no part here
  always_comb begin
    if (sel_q == lbs_pkg::SEL_L_Q) begin
      sec_fail = lim0_q != lbs_pkg::SEC_ALLPASS_LO && meas_sec_q < lim0_q;
    end else begin
      sec_fail = lim0_q != lbs_pkg::SEC_ALLPASS_HI && meas_sec_q > lim0_q;
    end
    res_d = '0;
    if (nom_q != '0) begin
      res_d.valid = 1'b1;
      if (sec_fail) begin
        res_d.fail = 1'b1;
        res_d.bin  = lbs_pkg::BIN_SEC;
      end else if (hit) begin
        res_d.pass = 1'b1;
        res_d.bin  = hit_bin;
      end else begin
        res_d.fail = 1'b1;
        res_d.bin  = lbs_pkg::BIN_FAIL;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      res_q     <= '0;
      delta_q   <= '0;
      GO_LAMP   <= 1'b0;
      NOGO_LAMP <= 1'b0;
      BIN_CODE  <= 4'h0;
      SORT_DONE <= 1'b0;
    end else begin
      SORT_DONE <= sort_go && nom_q != '0;
      if (sort_go) begin
        res_q     <= res_d;
        delta_q   <= meas_pri_q - $signed({8'h00, nom_q});
        GO_LAMP   <= res_d.pass;
        NOGO_LAMP <= res_d.fail;
        BIN_CODE  <= res_d.bin;
      end else if (ent_go && cmd_op == lbs_pkg::OP_NOM && nom_ok && nom_in == '0) begin
        res_q     <= '0;
        GO_LAMP   <= 1'b0;
        NOGO_LAMP <= 1'b0;
      end
    end
  end

  // ---------------- assertions ----------------
  default clocking dcb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  inhibit_lamps_a: assert property (nom_q == '0 |-> !GO_LAMP && !NOGO_LAMP)
    else $error("lamps lit with zero nominal");
  reset_closed_a: assert property ($past(SRST) |-> open_mask == '0 && nom_q == '0)
    else $error("bins open or nominal nonzero after reset");
  entry_gate_a: assert property (cmd_go && cmd_op == lbs_pkg::OP_NOM && !entry_q |=> $stable(nom_q))
    else $error("nominal changed outside entry mode");
  nom_echo_a: assert property (ent_go && cmd_op == lbs_pkg::OP_NOM && nom_ok |=> disp_pri_q == 32'(nom_q))
    else $error("nominal not echoed");
  bin_close_a: assert property (ent_go && cmd_op == lbs_pkg::OP_BIN && bin_rng && close_req
                                |=> !open_mask[$past(cmd_bin)])
    else $error("zero percent did not close bin");
  nom_keep_bins_a: assert property (cmd_go && cmd_op == lbs_pkg::OP_NOM |=> $stable(open_mask))
    else $error("nominal entry changed bin state");
  sec_fail_a: assert property (sort_go && nom_q != '0 && sec_fail
                               |=> NOGO_LAMP && !GO_LAMP && BIN_CODE == lbs_pkg::BIN_SEC)
    else $error("secondary failure not in bin 0");
  gap_fail_a: assert property (sort_go && nom_q != '0 && !sec_fail && match_vec == '0
                               |=> NOGO_LAMP && BIN_CODE == lbs_pkg::BIN_FAIL)
    else $error("unmatched part not in bin 9");
  lowest_bin_a: assert property (sort_go && nom_q != '0 && !sec_fail && match_vec != '0 |=> GO_LAMP
                                 && ($past(match_vec) & (9'h001 << BIN_CODE)) != '0
                                 && ($past(match_vec) & ((9'h001 << BIN_CODE) - 9'h001)) == '0)
    else $error("part not in lowest matching bin");
  nom_cap_a: assert property (nom_q <= lbs_pkg::NOM_CAP)
    else $error("nominal above cap");
  read_wait_a: assert property (HREADY && HREADYOUT && HSEL && HTRANS[1] && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");

  pass_sort_c: cover property (sort_go ##1 GO_LAMP);
  bin0_fail_c: cover property (sort_go ##1 NOGO_LAMP && BIN_CODE == lbs_pkg::BIN_SEC);
  bin9_fail_c: cover property (sort_go ##1 NOGO_LAMP && BIN_CODE == lbs_pkg::BIN_FAIL);
  recall_blank_c: cover property (ent_go && cmd_op == lbs_pkg::OP_RCL_BIN ##1 blank_q);

endmodule : lbs_top

// >>> inc/lbs_pkg.sv
package lbs_pkg;

  localparam int HADDR_W = 8;
  localparam int LW      = 40;
  localparam int NBINS   = 8;
  localparam int OP_W    = 3;
  localparam int BIN_W   = 4;

  // register byte offsets
  localparam logic [HADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [HADDR_W-1:0] OFF_VAL_A    = 8'h04;
  localparam logic [HADDR_W-1:0] OFF_VAL_B    = 8'h08;
  localparam logic [HADDR_W-1:0] OFF_CMD      = 8'h0C;
  localparam logic [HADDR_W-1:0] OFF_DISP_PRI = 8'h10;
  localparam logic [HADDR_W-1:0] OFF_DISP_SEC = 8'h14;
  localparam logic [HADDR_W-1:0] OFF_STATUS   = 8'h18;
  localparam logic [HADDR_W-1:0] OFF_MEAS_PRI = 8'h1C;
  localparam logic [HADDR_W-1:0] OFF_MEAS_SEC = 8'h20;
  localparam logic [HADDR_W-1:0] OFF_RESULT   = 8'h24;
  localparam logic [HADDR_W-1:0] OFF_DELTA    = 8'h28;
  localparam logic [HADDR_W-1:0] OFF_NOMINAL  = 8'h2C;

  // field positions
  localparam int CTRL_ENTRY_BIT = 0;
  localparam int CTRL_MULT_LSB  = 1;
  localparam int CTRL_SEL_LSB   = 3;
  localparam int CMD_OP_LSB     = 0;
  localparam int CMD_BIN_LSB    = 4;
  localparam int CMD_TWO_BIT    = 8;

  localparam logic [BIN_W-1:0] BIN_SEC   = 4'h0;
  localparam logic [BIN_W-1:0] BIN_FIRST = 4'h1;
  localparam logic [BIN_W-1:0] BIN_LAST  = 4'h8;
  localparam logic [BIN_W-1:0] BIN_FAIL  = 4'h9;

  // value limits, nominal and display values in tenths of the selected unit, percentages in tenths of a percent
  localparam logic [23:0]        NOM_CAP        = 24'h98_967F;
  localparam logic signed [31:0] PCT_CAP        = 32'sh000F_423F;
  localparam logic signed [63:0] DISP_MAX       = 64'sh0000_0000_000F_423F;
  localparam logic signed [LW-1:0] MSD4_MAX     = 40'sh00_0000_270F;
  localparam logic signed [LW-1:0] DEC_BASE     = 40'sh00_0000_000A;
  localparam int                 MSD_STEPS      = 8;
  localparam logic [31:0]        SEC_ALLPASS_HI = 32'h0000_270F;
  localparam logic [31:0]        SEC_ALLPASS_LO = 32'h0000_0000;
  localparam logic signed [47:0] PCT_SCALE      = 48'sh0000_0000_03E8;
  localparam logic signed [63:0] MULT_STEP      = 64'sh0000_0000_0000_03E8;
  localparam int                 MULT_STEPS_MAX = 3;
  localparam logic [1:0]         MULT_ENTRY_MAX = 2'h2;

  typedef enum logic [OP_W-1:0] {
    OP_NONE    = 3'h0,
    OP_NOM     = 3'h1,
    OP_BIN     = 3'h2,
    OP_RCL_NOM = 3'h3,
    OP_RCL_BIN = 3'h4,
    OP_SORT    = 3'h5
  } lbs_op_t;

  typedef enum logic [1:0] {
    SEL_R_Q = 2'h0,
    SEL_C_D = 2'h1,
    SEL_L_Q = 2'h2
  } lbs_sel_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_READ = 1'b1
  } lbs_bus_t;

  typedef struct packed {
    logic               sel;
    logic               write;
    logic [HADDR_W-1:0] addr;
  } lbs_aph_t;

  typedef struct packed {
    logic                 open;
    logic [1:0]           mult;
    logic signed [LW-1:0] hi;
    logic signed [LW-1:0] lo;
  } lbs_bin_t;

  typedef struct packed {
    logic             valid;
    logic             fail;
    logic             pass;
    logic [BIN_W-1:0] bin;
  } lbs_res_t;

endpackage : lbs_pkg

// >>> testbench/lbs_oper.sv
`timescale 1ns/10ps
module lbs_oper (
  input  wire logic        CORE_CLK,
  input  wire logic        HREADY,
  input  wire logic [31:0] HRDATA,
  output logic             HSEL,
  output logic [31:0]      HADDR,
  output logic [1:0]       HTRANS,
  output logic             HWRITE,
  output logic [2:0]       HSIZE,
  output logic [31:0]      HWDATA
);
  logic        rdy_s;
  logic [31:0] dat_s;
  initial begin
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
  end
  // bus values as seen at the edge, free of update races
  always @(posedge CORE_CLK) begin
    rdy_s <= HREADY;
    dat_s <= HRDATA;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h00_0000, a};
    do begin
      @(posedge CORE_CLK);
      #1;
    end while (rdy_s !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do begin
      @(posedge CORE_CLK);
      #1;
    end while (rdy_s !== 1'b1);
    q = dat_s;
  endtask : xfer
endmodule : lbs_oper

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        CORE_CLK = 1'b0;
  logic        SRST = 1'b1;
  logic        HSEL, HWRITE, HREADYOUT, HRESP, GO_LAMP, NOGO_LAMP, SORT_DONE;
  logic [31:0] HADDR, HWDATA, HRDATA, q;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [3:0]  BIN_CODE;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #4 CORE_CLK = ~CORE_CLK;
  lbs_top dut_u (.CORE_CLK(CORE_CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .GO_LAMP(GO_LAMP), .NOGO_LAMP(NOGO_LAMP),
    .BIN_CODE(BIN_CODE), .SORT_DONE(SORT_DONE));
  lbs_oper oper_u (.CORE_CLK(CORE_CLK), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA));
  task automatic give_verdict;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    oper_u.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    oper_u.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  // one measured part through the sorter, result and lamps judged
  task automatic sort(input logic [31:0] m, input logic [31:0] e);
    wr(lbs_pkg::OFF_MEAS_PRI, m);
    wr(lbs_pkg::OFF_CMD, 32'h5);
    chk({31'h0, SORT_DONE}, {31'h0, e[6]});
    rd(lbs_pkg::OFF_RESULT);
    chk(q & 32'h7F, e);
    chk({25'h0, HRESP, BIN_CODE, GO_LAMP, NOGO_LAMP}, {25'h0, 1'b0, e[3:0], e[4], e[5]});
  endtask : sort
  task automatic t_entry;
    rd(lbs_pkg::OFF_STATUS);
    chk(q & 32'h7FC, 32'h400);
    wr(lbs_pkg::OFF_CTRL, 32'h1);
    wr(lbs_pkg::OFF_VAL_A, 32'h7D0);
    wr(lbs_pkg::OFF_CMD, 32'h1);
    wr(lbs_pkg::OFF_VAL_A, 32'h3E8);
    wr(lbs_pkg::OFF_CMD, 32'h1);
    rd(lbs_pkg::OFF_DISP_PRI);
    chk(q, 32'h3E8);
    wr(lbs_pkg::OFF_VAL_A, 32'h14);
    wr(lbs_pkg::OFF_CMD, 32'h12);
    rd(lbs_pkg::OFF_DISP_PRI);
    chk(q, 32'h3FC);
    rd(lbs_pkg::OFF_DISP_SEC);
    chk(q, 32'h3D4);
    wr(lbs_pkg::OFF_VAL_A, 32'h3C);
    wr(lbs_pkg::OFF_VAL_B, 32'hFFFF_FFD8);
    wr(lbs_pkg::OFF_CMD, 32'h122);
    rd(lbs_pkg::OFF_DISP_SEC);
    chk(q, 32'h3C0);
    rd(lbs_pkg::OFF_STATUS);
    chk(q & 32'h3FC, 32'hC);
    wr(lbs_pkg::OFF_VAL_A, 32'h7D0);
    wr(lbs_pkg::OFF_CMD, 32'h1);
    wr(lbs_pkg::OFF_CMD, 32'h14);
    rd(lbs_pkg::OFF_DISP_PRI);
    chk(q, 32'h3FC);
    wr(lbs_pkg::OFF_VAL_A, 32'h3E8);
    wr(lbs_pkg::OFF_CMD, 32'h1);
    $display("done entry");
  endtask : t_entry
  task automatic t_sort;
    wr(lbs_pkg::OFF_CTRL, 32'h0);
    wr(lbs_pkg::OFF_MEAS_SEC, 32'hA);
    sort(32'h3F2, 32'h51);
    sort(32'h410, 32'h52);
    sort(32'h7D0, 32'h69);
    rd(lbs_pkg::OFF_DELTA);
    chk(q, 32'h3E8);
    wr(lbs_pkg::OFF_CTRL, 32'h1);
    wr(lbs_pkg::OFF_VAL_A, 32'h5);
    wr(lbs_pkg::OFF_CMD, 32'h2);
    rd(lbs_pkg::OFF_DISP_SEC);
    chk(q, 32'h5);
    wr(lbs_pkg::OFF_CTRL, 32'h0);
    sort(32'h3F2, 32'h60);
    wr(lbs_pkg::OFF_CTRL, 32'h10);
    sort(32'h3F2, 32'h51);
    $display("done sort");
  endtask : t_sort
  task automatic t_inhibit;
    wr(lbs_pkg::OFF_CTRL, 32'h11);
    wr(lbs_pkg::OFF_VAL_A, 32'h0);
    wr(lbs_pkg::OFF_CMD, 32'h1);
    wr(lbs_pkg::OFF_CTRL, 32'h10);
    sort(32'h3F2, 32'h0);
    wr(lbs_pkg::OFF_CTRL, 32'h11);
    wr(lbs_pkg::OFF_VAL_A, 32'h3E8);
    wr(lbs_pkg::OFF_CMD, 32'h1);
    wr(lbs_pkg::OFF_CTRL, 32'h10);
    sort(32'h3F2, 32'h51);
    $display("done inhibit");
  endtask : t_inhibit
  // recall rescaling and blanking, bin close, refused nominal entries
  task automatic t_recall;
    wr(lbs_pkg::OFF_CTRL, 32'h3);
    wr(lbs_pkg::OFF_CMD, 32'h3);
    rd(lbs_pkg::OFF_DISP_PRI);
    chk(q, 32'h1);
    wr(lbs_pkg::OFF_VAL_A, 32'h3E8);
    wr(lbs_pkg::OFF_CMD, 32'h1);
    wr(lbs_pkg::OFF_VAL_A, 32'h14);
    wr(lbs_pkg::OFF_CMD, 32'h32);
    wr(lbs_pkg::OFF_CTRL, 32'h1);
    wr(lbs_pkg::OFF_CMD, 32'h34);
    rd(lbs_pkg::OFF_STATUS);
    chk(q & 32'h3FF, 32'h1D);
    wr(lbs_pkg::OFF_VAL_A, 32'h0);
    wr(lbs_pkg::OFF_CMD, 32'h32);
    wr(lbs_pkg::OFF_CTRL, 32'h7);
    wr(lbs_pkg::OFF_VAL_A, 32'h7D0);
    wr(lbs_pkg::OFF_CMD, 32'h1);
    rd(lbs_pkg::OFF_STATUS);
    chk(q & 32'h3FF, 32'hE);
    wr(lbs_pkg::OFF_CTRL, 32'h0);
    wr(lbs_pkg::OFF_CMD, 32'h1);
    rd(lbs_pkg::OFF_NOMINAL);
    chk(q, 32'h3E8);
    $display("done recall");
  endtask : t_recall
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge CORE_CLK);
    SRST <= 1'b0;
    #1;
    t_entry();
    t_sort();
    t_inhibit();
    t_recall();
    give_verdict();
  end
endmodule : tb_top
